// >>> logic/css_ctrl.sv
`default_nettype none
// Notes on behaviour
// - reset clears both control registers; cpu runs main clock at slowest rate
// - on main clock, low two processor bits pick divide by 64, 16, 8 or 4
// - on main clock both stop and halt standby modes are available
// - on subsystem clock select bits ignored; cpu clock is subsystem divided by four
// - on subsystem clock halt allowed, stop refused, subsystem oscillator never stopped
// - peripheral ticks come from main clock; watch tick comes straight from subsystem
// - with main oscillator stopped peripheral ticks cease; watch tick runs, and cpu tick too if stopped by the system register bit
// - processor register is four bits: two clock select, two standby mode
// - either mode bit set means standby; release signal clears both
// - a four-bit write loads select bits and forces both mode bits to zero
// - stop instruction sets bit 3, halt sets bit 2, bank flag irrelevant
// - stop instruction accepted only while cpu runs from main oscillator
// - system register at FB7H: bit 0 source, bit 3 main oscillator stop
// - encoding: 00 main, 01 sub, 11 sub with main stopped, 10 prohibited
// - source and oscillator-stop bits never change together; single-bit writes always work
// - oscillator-stop bit stops main only while on subsystem clock, never enters stop
// - source change takes effect within one subsystem period
// - oscillator-stop ties main input pin low; never with external main clock
module css_ctrl
	import css_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// oscillator waveforms from the pins
	input wire logic main_osc_input_pin,
	input wire logic sub_osc_pin,
	// register access and instructions from the cpu core
	input wire css_cpu_req_t cpu_req,
	input wire logic stop_instr,
	input wire logic halt_instr,
	input wire logic standby_release,
	output logic [3:0] rdata,
	output logic rdata_valid,
	// clock enables
	output logic cpu_clk_en,
	output logic periph_clk_en,
	output logic watch_clk_en,
	// oscillator control and status
	output logic main_osc_enable,
	output logic main_osc_clamp,
	output css_status_t status
);

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic m_s1, m_s2, m_s3;
	logic s_s1, s_s2, s_s3;
	logic main_rise, sub_rise;

	// third stage only feeds the edge detectors, never the first
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			m_s1 <= 1'b0;
			m_s2 <= 1'b0;
			m_s3 <= 1'b0;
			s_s1 <= 1'b0;
			s_s2 <= 1'b0;
			s_s3 <= 1'b0;
		end else begin
			m_s1 <= main_osc_input_pin;
			m_s2 <= m_s1;
			m_s3 <= m_s2;
			s_s1 <= sub_osc_pin;
			s_s2 <= s_s1;
			s_s3 <= s_s2;
		end
	end

	logic main_run;
	// a stopped oscillator gives no ticks even if the pin still wiggles
	assign main_rise = m_s2 & ~m_s3 & main_run;
	assign sub_rise = s_s2 & ~s_s3;

	////////////////////////////////////////////////////////////////////////
	// control registers
	logic [3:0] cpu_clock_and_standby_reg, next_pcc;
	logic [3:0] system_clock_select_reg, next_scc;
	logic [3:0] next_rdata;
	logic next_rdata_valid, next_main_run;
	logic hit_pcc, hit_scc;
	css_src_t state, next_state;

	assign hit_pcc = cpu_req.addr == CSS_PCC_ADDR;
	assign hit_scc = cpu_req.addr == CSS_SCC_ADDR;

	// instruction sets are applied after the release so a set wins
	always_comb begin
		next_pcc = cpu_clock_and_standby_reg;
		next_scc = system_clock_select_reg;
		next_rdata = rdata;
		if (cpu_req.wr4 && hit_pcc) begin
			next_pcc = {2'b00, cpu_req.wdata[1:0]};
		end
		// a nibble write that would flip both bits is dropped whole
		if (cpu_req.wr4 && hit_scc && !((cpu_req.wdata[CSS_SCC_OSTOP] != system_clock_select_reg[CSS_SCC_OSTOP])
				&& (cpu_req.wdata[CSS_SCC_SRC] != system_clock_select_reg[CSS_SCC_SRC]))) begin
			next_scc[CSS_SCC_OSTOP] = cpu_req.wdata[CSS_SCC_OSTOP];
			next_scc[CSS_SCC_SRC] = cpu_req.wdata[CSS_SCC_SRC];
		end
		// single-bit writes need no bank flag
		if (cpu_req.bit_wr && hit_scc) begin
			if (cpu_req.bit_sel == 2'(CSS_SCC_OSTOP)) begin
				next_scc[CSS_SCC_OSTOP] = cpu_req.bit_val;
			end
			if (cpu_req.bit_sel == 2'(CSS_SCC_SRC)) begin
				next_scc[CSS_SCC_SRC] = cpu_req.bit_val;
			end
		end
		if (standby_release) begin
			next_pcc[CSS_PCC_STOP] = 1'b0;
			next_pcc[CSS_PCC_HALT] = 1'b0;
		end
		if (halt_instr) begin
			next_pcc[CSS_PCC_HALT] = 1'b1;
		end
		if (stop_instr && state == CSS_MAIN) begin
			next_pcc[CSS_PCC_STOP] = 1'b1;
		end
		// unused system bits read as zero
		if (cpu_req.rd) begin
			next_rdata = hit_pcc ? cpu_clock_and_standby_reg : (hit_scc ? {system_clock_select_reg[3], 2'b00, system_clock_select_reg[0]} : 4'h0);
		end
		next_rdata_valid = cpu_req.rd;
		// on main clock the stop bit is only stored; stop instruction stops it
		next_main_run = ~next_pcc[CSS_PCC_STOP] & ~(system_clock_select_reg[CSS_SCC_OSTOP] & (state == CSS_SUB));
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			cpu_clock_and_standby_reg <= CSS_PCC_RST;
			system_clock_select_reg <= CSS_SCC_RST;
			rdata <= 4'h0;
			rdata_valid <= 1'b0;
			main_run <= 1'b1;
		end else begin
			cpu_clock_and_standby_reg <= next_pcc;
			system_clock_select_reg <= next_scc;
			rdata <= next_rdata;
			rdata_valid <= next_rdata_valid;
			main_run <= next_main_run;
		end
	end

	assign main_osc_enable = main_run;
	assign main_osc_clamp = ~main_run;
	assign status = '{stop: cpu_clock_and_standby_reg[CSS_PCC_STOP], halt: cpu_clock_and_standby_reg[CSS_PCC_HALT],
		on_sub: (state == CSS_SUB) || (state == CSS_TO_MAIN), main_run: main_run};

	////////////////////////////////////////////////////////////////////////
	// source sequencer and machine-cycle divider
	logic [5:0] cnt, next_cnt, tc;
	logic [1:0] sel_act, next_sel_act;
	logic tick_src, boundary, switching;
	logic next_cpu_clk_en, next_periph_clk_en, next_watch_clk_en;

	// main-side states still count main ticks until the switch lands
	always_comb begin
		tick_src = ((state == CSS_MAIN) || (state == CSS_TO_SUB)) ? main_rise : sub_rise;
		tc = CSS_TC_SUB;
		if ((state == CSS_MAIN) || (state == CSS_TO_SUB)) begin
			case (sel_act)
				CSS_SEL_DIV64: tc = CSS_TC_DIV64;
				CSS_SEL_DIV16: tc = CSS_TC_DIV16;
				CSS_SEL_DIV8: tc = CSS_TC_DIV8;
				default: tc = CSS_TC_DIV4;
			endcase
		end
		boundary = tick_src && (cnt == tc);
	end

	// the switch lands on the next subsystem edge; the partial cycle is
	// dropped, so a cycle may stretch but never shortens
	always_comb begin
		next_state = state;
		switching = 1'b0;
		case (state)
			CSS_MAIN: begin
				if (system_clock_select_reg[CSS_SCC_SRC]) begin
					next_state = CSS_TO_SUB;
				end
			end
			CSS_TO_SUB: begin
				if (!system_clock_select_reg[CSS_SCC_SRC]) begin
					next_state = CSS_MAIN;
				end else if (sub_rise) begin
					next_state = CSS_SUB;
					switching = 1'b1;
				end
			end
			CSS_SUB: begin
				if (!system_clock_select_reg[CSS_SCC_SRC]) begin
					next_state = CSS_TO_MAIN;
				end
			end
			CSS_TO_MAIN: begin
				if (system_clock_select_reg[CSS_SCC_SRC]) begin
					next_state = CSS_SUB;
				end else if (sub_rise) begin
					next_state = CSS_MAIN;
					switching = 1'b1;
				end
			end
			default: begin
				next_state = CSS_MAIN;
			end
		endcase
		next_cnt = cnt;
		if (switching) begin
			next_cnt = CSS_CNT_RST;
		end else if (tick_src) begin
			next_cnt = boundary ? CSS_CNT_RST : 6'(cnt + 6'h01);
		end
		// select changes only take hold at a machine-cycle boundary or when a source switch lands
		next_sel_act = (boundary || switching) ? cpu_clock_and_standby_reg[1:0] : sel_act;
		next_cpu_clk_en = boundary && !switching && !cpu_clock_and_standby_reg[CSS_PCC_STOP]
			&& !cpu_clock_and_standby_reg[CSS_PCC_HALT];
		next_periph_clk_en = main_rise;
		next_watch_clk_en = sub_rise;
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			state <= CSS_MAIN;
			cnt <= CSS_CNT_RST;
			sel_act <= CSS_SEL_RST;
			cpu_clk_en <= 1'b0;
			periph_clk_en <= 1'b0;
			watch_clk_en <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			sel_act <= next_sel_act;
			cpu_clk_en <= next_cpu_clk_en;
			periph_clk_en <= next_periph_clk_en;
			watch_clk_en <= next_watch_clk_en;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	sequence s_sub_boundary;
		state == CSS_SUB && sub_rise && cnt == CSS_TC_SUB;
	endsequence
	sequence s_awake;
		cpu_clock_and_standby_reg[3:2] == 2'b00;
	endsequence

	property p_reset_clear;
		disable iff (1'b0) !reset_n |=> (cpu_clock_and_standby_reg == CSS_PCC_RST && system_clock_select_reg == CSS_SCC_RST
			&& !cpu_clk_en && state == CSS_MAIN);
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("reset state wrong");

	property p_wr4_mode;
		cpu_req.wr4 && hit_pcc && !halt_instr && !stop_instr |=>
			cpu_clock_and_standby_reg == {2'b00, $past(cpu_req.wdata[1:0])};
	endproperty
	a_wr4_mode: assert property (p_wr4_mode) else $error("nibble write bad");

	property p_release;
		standby_release && !halt_instr && !stop_instr |=> cpu_clock_and_standby_reg[3:2] == 2'b00;
	endproperty
	a_release: assert property (p_release) else $error("release kept standby");

	property p_stop_refused;
		state != CSS_MAIN && !cpu_clock_and_standby_reg[CSS_PCC_STOP] |=> !cpu_clock_and_standby_reg[CSS_PCC_STOP];
	endproperty
	a_stop_refused: assert property (p_stop_refused) else $error("stop taken on sub");

	property p_stop_taken;
		stop_instr && state == CSS_MAIN |=> cpu_clock_and_standby_reg[CSS_PCC_STOP] ##1 !main_osc_enable;
	endproperty
	a_stop_taken: assert property (p_stop_taken) else $error("stop not taken");

	property p_standby_gate;
		cpu_clock_and_standby_reg[3:2] != 2'b00 |=> !cpu_clk_en;
	endproperty
	a_standby_gate: assert property (p_standby_gate) else $error("cpu ran in standby");

	property p_sub_tick;
		s_sub_boundary ##0 s_awake |=> cpu_clk_en;
	endproperty
	a_sub_tick: assert property (p_sub_tick) else $error("sub cycle missed");

	property p_main_runs;
		state == CSS_MAIN && !cpu_clock_and_standby_reg[CSS_PCC_STOP] && !stop_instr |=> main_osc_enable;
	endproperty
	a_main_runs: assert property (p_main_runs) else $error("main stopped on main");

	property p_osc_stop;
		system_clock_select_reg[CSS_SCC_OSTOP] && state == CSS_SUB && !cpu_clock_and_standby_reg[CSS_PCC_STOP] |=>
			main_osc_clamp ##1 !periph_clk_en;
	endproperty
	a_osc_stop: assert property (p_osc_stop) else $error("main not stopped");

	property p_no_dual;
		cpu_req.wr4 && hit_scc && !cpu_req.bit_wr && cpu_req.wdata[3] != system_clock_select_reg[3]
			&& cpu_req.wdata[0] != system_clock_select_reg[0] |=> $stable(system_clock_select_reg);
	endproperty
	a_no_dual: assert property (p_no_dual) else $error("dual change taken");

	property p_watch;
		s_s2 && !s_s3 |=> watch_clk_en;
	endproperty
	a_watch: assert property (p_watch) else $error("watch tick lost");

endmodule
`default_nettype wire

// >>> logic/css_pkg.sv
`default_nettype none
package css_pkg;
	// data memory addresses of the two control registers
	localparam logic [11:0] CSS_SCC_ADDR = 12'hFB7;
	localparam logic [11:0] CSS_PCC_ADDR = 12'hFB3;
	// values after reset
	localparam logic [3:0] CSS_PCC_RST = 4'h0;
	localparam logic [3:0] CSS_SCC_RST = 4'h0;
	localparam logic [5:0] CSS_CNT_RST = 6'h00;
	localparam logic [1:0] CSS_SEL_RST = 2'h0;
	// field positions
	localparam int CSS_PCC_STOP = 3;
	localparam int CSS_PCC_HALT = 2;
	localparam int CSS_SCC_OSTOP = 3;
	localparam int CSS_SCC_SRC = 0;
	// cpu clock select codes
	localparam logic [1:0] CSS_SEL_DIV64 = 2'h0;
	localparam logic [1:0] CSS_SEL_DIV16 = 2'h1;
	localparam logic [1:0] CSS_SEL_DIV8 = 2'h2;
	localparam logic [1:0] CSS_SEL_DIV4 = 2'h3;
	// terminal counts of the machine-cycle divider, in oscillator ticks
	localparam logic [5:0] CSS_TC_DIV64 = 6'h3F;
	localparam logic [5:0] CSS_TC_DIV16 = 6'h0F;
	localparam logic [5:0] CSS_TC_DIV8 = 6'h07;
	localparam logic [5:0] CSS_TC_DIV4 = 6'h03;
	localparam logic [5:0] CSS_TC_SUB = 6'h03;
	// access from the cpu core
	typedef struct packed {
		logic wr4;
		logic bit_wr;
		logic rd;
		logic [11:0] addr;
		logic [3:0] wdata;
		logic [1:0] bit_sel;
		logic bit_val;
	} css_cpu_req_t;
	// state shown to the standby logic
	typedef struct packed {
		logic stop;
		logic halt;
		logic on_sub;
		logic main_run;
	} css_status_t;
	// cpu clock source sequencer
	typedef enum logic [3:0] {
		CSS_MAIN = 4'h1,
		CSS_TO_SUB = 4'h2,
		CSS_SUB = 4'h4,
		CSS_TO_MAIN = 4'h8
	} css_src_t;
endpackage
`default_nettype wire

// >>> verif/css_ctrl_tb.sv
`default_nettype none
module css_ctrl_tb import css_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys, reset_n, stop_instr, halt_instr, standby_release;
	css_cpu_req_t cpu_req;
	wire logic main_pin;
	wire logic sub_pin;
	logic [3:0] rdata;
	logic rdata_valid, cpu_en, per_en, wat_en, osc_en, clamp;
	css_status_t status;
	int err_total, num_checks, k;
	logic [15:0] n, c, p, w;
	logic [15:0] div_exp [4] = '{16'h40, 16'h10, 16'h8, 16'h4};
	////////////////////////////////////////////////////////////////////////
	css_ctrl dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .main_osc_input_pin(main_pin),
		.sub_osc_pin(sub_pin), .cpu_req(cpu_req), .stop_instr(stop_instr),
		.halt_instr(halt_instr), .standby_release(standby_release), .rdata(rdata),
		.rdata_valid(rdata_valid), .cpu_clk_en(cpu_en), .periph_clk_en(per_en),
		.watch_clk_en(wat_en), .main_osc_enable(osc_en), .main_osc_clamp(clamp),
		.status(status));
	css_osc_model osc_u (.main_osc_enable(osc_en), .main_osc_clamp(clamp),
		.main_osc_input_pin(main_pin), .sub_osc_pin(sub_pin));
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	////////////////////////////////////////////////////////////////////////
	task check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask
	task tally_and_finish;
		if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// one-cycle register access, taken at the second edge
	task acc(input logic w4, input logic bw, input logic [11:0] a, input logic [3:0] d,
		input logic [1:0] bs, input logic bv);
		@(posedge clk_sys);
		cpu_req <= '{wr4:w4, bit_wr:bw, rd:1'b0, addr:a, wdata:d, bit_sel:bs, bit_val:bv};
		@(posedge clk_sys);
		cpu_req <= '0;
	endtask
	task rd_chk(input logic [11:0] a, input logic [3:0] exp);
		@(posedge clk_sys);
		cpu_req <= '{rd:1'b1, addr:a, default:'0};
		@(posedge clk_sys);
		cpu_req <= '0;
		#1;
		check({11'h0, rdata_valid, rdata}, {11'h1, exp});
	endtask
	// the cycle after an instruction carries none, standing in for the nop that must follow
	task instr(input logic s, input logic h, input logic r);
		@(posedge clk_sys);
		{stop_instr, halt_instr, standby_release} <= {s, h, r};
		@(posedge clk_sys);
		{stop_instr, halt_instr, standby_release} <= 3'h0;
	endtask
	// ticks between the 2nd and 3rd cpu pulse; the first period may be the old rate
	task meas(input logic use_wat, output logic [15:0] cnt);
		int seen, i;
		seen = 0;
		cnt = '0;
		for (i = 0; i < 20000 && seen < 3; i++) begin
			@(posedge clk_sys);
			#1;
			if (seen == 2 && (use_wat ? wat_en : per_en) === 1'b1) cnt++;
			if (cpu_en === 1'b1) seen++;
		end
	endtask
	task win(output logic [15:0] cc, output logic [15:0] pc, output logic [15:0] wc);
		{cc, pc, wc} = '0;
		repeat (600) begin
			@(posedge clk_sys);
			#1;
			if (cpu_en === 1'b1) cc++;
			if (per_en === 1'b1) pc++;
			if (wat_en === 1'b1) wc++;
		end
	endtask
	// a source switch must land within about one subsystem period
	task wait_src(input logic v);
		int i;
		for (i = 0; i < 100 && status.on_sub !== v; i++) begin
			@(posedge clk_sys);
			#1;
		end
		check({15'h0, status.on_sub}, {15'h0, v});
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		{reset_n, stop_instr, halt_instr, standby_release} = 4'h0;
		cpu_req = '0;
		err_total = 0;
		num_checks = 0;
		repeat (8) @(posedge clk_sys);
		reset_n <= 1'b1;
		#1;
		check({12'h0, status}, 16'h1);
		rd_chk(CSS_PCC_ADDR, 4'h0);
		rd_chk(CSS_SCC_ADDR, 4'h0);
		rd_chk(12'hFB0, 4'h0);
		acc(1'b1, 1'b0, CSS_PCC_ADDR, 4'hF, 2'h0, 1'b0);
		rd_chk(CSS_PCC_ADDR, 4'h3);
		for (k = 0; k < 4; k++) begin
			acc(1'b1, 1'b0, CSS_PCC_ADDR, k[3:0], 2'h0, 1'b0);
			meas(1'b0, n);
			check(n, div_exp[k]);
		end
		// halt on main: cpu pulses stop until release
		instr(1'b0, 1'b1, 1'b0);
		rd_chk(CSS_PCC_ADDR, 4'h7);
		win(c, p, w);
		check(c, 16'h0);
		instr(1'b0, 1'b0, 1'b1);
		rd_chk(CSS_PCC_ADDR, 4'h3);
		// stop on main: main oscillator off, watch tick alive
		instr(1'b1, 1'b0, 1'b0);
		repeat (3) @(posedge clk_sys);
		#1;
		check({15'h0, osc_en}, 16'h0);
		rd_chk(CSS_PCC_ADDR, 4'hB);
		win(c, p, w);
		check(p, 16'h0);
		check({15'h0, w != 16'h0}, 16'h1);
		instr(1'b0, 1'b0, 1'b1);
		rd_chk(CSS_PCC_ADDR, 4'h3);
		// refused writes to the system register, then an oscillator-stop bit stored on main that leaves main running
		acc(1'b1, 1'b0, CSS_SCC_ADDR, 4'h9, 2'h0, 1'b0);
		rd_chk(CSS_SCC_ADDR, 4'h0);
		acc(1'b0, 1'b1, CSS_SCC_ADDR, 4'h0, 2'h1, 1'b1);
		rd_chk(CSS_SCC_ADDR, 4'h0);
		acc(1'b0, 1'b1, CSS_SCC_ADDR, 4'h0, 2'h3, 1'b1);
		repeat (4) @(posedge clk_sys);
		#1;
		check({14'h0, osc_en, clamp}, 16'h2);
		acc(1'b0, 1'b1, CSS_SCC_ADDR, 4'h0, 2'h3, 1'b0);
		// move to the subsystem clock
		// processor register select bits hold 11 here, never 01, for the whole subsystem stretch
		acc(1'b0, 1'b1, CSS_SCC_ADDR, 4'h0, 2'h0, 1'b1);
		wait_src(1'b1);
		rd_chk(CSS_SCC_ADDR, 4'h1);
		meas(1'b1, n);
		check(n, 16'h4);
		instr(1'b1, 1'b0, 1'b0);
		rd_chk(CSS_PCC_ADDR, 4'h3);
		acc(1'b0, 1'b1, CSS_SCC_ADDR, 4'h0, 2'h3, 1'b1);
		repeat (3) @(posedge clk_sys);
		#1;
		check({13'h0, osc_en, clamp, status.on_sub}, 16'h3);
		rd_chk(CSS_SCC_ADDR, 4'h9);
		win(c, p, w);
		check(p, 16'h0);
		meas(1'b1, n);
		check(n, 16'h4);
		instr(1'b0, 1'b1, 1'b0);
		rd_chk(CSS_PCC_ADDR, 4'h7);
		instr(1'b0, 1'b0, 1'b1);
		// back to the main clock at the selected rate
		acc(1'b0, 1'b1, CSS_SCC_ADDR, 4'h0, 2'h3, 1'b0);
		repeat (20) @(posedge clk_sys);
		acc(1'b0, 1'b1, CSS_SCC_ADDR, 4'h0, 2'h0, 1'b0);
		wait_src(1'b0);
		meas(1'b0, n);
		check(n, 16'h4);
		tally_and_finish;
	end
	// watchdog at 40000 cycles, well beyond the expected run of about 7000 cycles
	initial begin
		#1000000;
		err_total++;
		tally_and_finish;
	end
endmodule
`default_nettype wire

// >>> verif/css_osc_model.sv
`default_nettype none
// crystal pair as seen from the pins; periods scaled down to keep runs short
module css_osc_model (
	// oscillator control from the block
	input wire logic main_osc_enable,
	input wire logic main_osc_clamp,
	// pin waveforms
	output wire logic main_osc_input_pin,
	output wire logic sub_osc_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic main_ph;
	logic sub_ph;
	////////////////////////////////////////////////////////////////////////
	// free-running phases; the subsystem crystal is never stopped
	initial begin
		main_ph = 1'b0;
		forever #100 main_ph = ~main_ph;
	end
	initial begin
		sub_ph = 1'b0;
		forever #1000 sub_ph = ~sub_ph;
	end
	////////////////////////////////////////////////////////////////////////
	// a clamped pin sits at ground, so no edge can reach the block
	assign main_osc_input_pin = main_ph & main_osc_enable & ~main_osc_clamp;
	assign sub_osc_pin = sub_ph;
endmodule
`default_nettype wire
